/* File: hw/dac_link_pkg.sv */
package dac_link_pkg;
    // frame geometry
    localparam int WORD_W = 16;                 // input shift register width
    localparam int CHAN_N = 8;                  // converter channels
    localparam int CODE_W = 8;                  // code width per channel
    localparam int CNT_W  = 5;                  // falling-edge counter width

    // edge counts within one frame
    localparam logic [CNT_W-1:0] CNT_ZERO  = 5'h00;
    localparam logic [CNT_W-1:0] CNT_FULL  = 5'h10; // sixteen edges seen
    localparam logic [CNT_W-1:0] CNT_CHAIN = 5'h11; // first surplus edge
    localparam logic [CNT_W-1:0] CNT_MAX   = 5'h1f; // counter saturates

    // command word layout
    localparam int CMD_MSB  = 15;
    localparam int CMD_LSB  = 12;
    localparam int DATA_MSB = 11;
    localparam int DATA_LSB = 4;
    localparam int MASK_MSB = 7;
    localparam int MASK_LSB = 0;
    localparam int CHAN_MSB = 2;                // channel index bits of cmd
    localparam int SEL_BIT  = 3;                // cmd high bit: not a single-channel write

    // command codes: 0..7 write one channel
    localparam logic [3:0] CMD_ALL = 4'h8;      // write every channel
    localparam logic [3:0] CMD_PWR = 4'h9;      // load power-down mask

    // reset values
    localparam logic [CODE_W-1:0] CODE_RST = 8'h00;
    localparam logic [CHAN_N-1:0] MASK_RST = 8'h00;
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
    localparam logic [2:0]        PIN_RST  = 3'h6; // {frame_n, sclk, din}
endpackage

/* File: hw/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync
    import dac_link_pkg::*;
#(
    parameter int              WIDTH   = 3,
    parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    // raw pins
    input  wire logic [WIDTH-1:0] i_pin,
    // synchronised level and edges
    output logic      [WIDTH-1:0] o_level,
    output logic      [WIDTH-1:0] o_rise,
    output logic      [WIDTH-1:0] o_fall
);

    logic [WIDTH-1:0] meta_reg;    // first stage, read only by second
    logic [WIDTH-1:0] level_reg;   // second stage, safe to use
    logic [WIDTH-1:0] last_reg;    // one cycle older, for edges

    // two-flop synchroniser plus history stage
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            meta_reg  <= RST_VAL;
            level_reg <= RST_VAL;
            last_reg  <= RST_VAL;
        end
        else
        begin
            meta_reg  <= i_pin;
            level_reg <= meta_reg;
            last_reg  <= level_reg;
        end
    end

    // edges come from settled stages only
    assign o_level = level_reg;
    assign o_rise  = level_reg & ~last_reg;
    assign o_fall  = ~level_reg & last_reg;
endmodule

/* File: hw/dac_frame_input.sv */
`timescale 1ns/1ps
module dac_frame_input
    import dac_link_pkg::*;
(
    // clock and reset
    input  wire logic                     I_CLK,
    input  wire logic                     I_SYS_RST,
    // serial link pins
    input  wire logic                     I_SCLK,
    input  wire logic                     I_FRAME_N,
    input  wire logic                     I_SDI,
    output logic                          O_SDO_CHAIN,
    // converter side
    output logic [CHAN_N*CODE_W-1:0]      O_CODE,
    output logic [CHAN_N-1:0]             O_PWR_DOWN,
    output logic [WORD_W-1:0]             O_WORD,
    output logic                          O_UPDATE,
    output logic                          O_ABORT
);

    // decode: does this command write channel idx
    function automatic logic chan_hit(input logic [3:0] cmd,
                                      input int         idx);
        logic [CHAN_MSB:0] sel;
        sel = idx[CHAN_MSB:0];
        chan_hit = (cmd == CMD_ALL) ||
                   (!cmd[SEL_BIT] && cmd[CHAN_MSB:0] == sel);
    endfunction

    logic [2:0]              pin_lvl;     // {frame_n, sclk, sdi}
    logic [2:0]              pin_rise;    // rising edges
    logic [2:0]              pin_fall;    // falling edges
    logic                    sdi_s;       // synced data level
    logic                    framed;      // frame select held low
    logic                    frame_start; // frame select fell
    logic                    frame_end;   // frame select rose
    logic                    shift_en;    // one data bit to take
    logic                    commit;      // complete word accepted
    logic [CNT_W-1:0]        cnt_reg;     // falling edges in frame
    logic [WORD_W-1:0]       shift_reg;   // input shift register
    logic                    sdo_reg;     // chained output bit
    logic [CODE_W-1:0]       code_reg [CHAN_N]; // per-channel codes
    logic [CHAN_N-1:0]       pd_reg;      // power-down mask
    logic [WORD_W-1:0]       word_reg;    // last committed word
    logic                    upd_reg;     // update strobe
    logic                    abort_reg;   // abort strobe
    logic                    seen_reg;    // helper: a write landed

    // all three pins go through the same synchroniser, so data and
    // clock stay aligned to the cycle
    pin_sync #(
        .WIDTH   (3),
        .RST_VAL (PIN_RST)
    ) u_pins (
        .i_clk   (I_CLK),
        .i_rst   (I_SYS_RST),
        .i_pin   ({I_FRAME_N, I_SCLK, I_SDI}),
        .o_level (pin_lvl),
        .o_rise  (pin_rise),
        .o_fall  (pin_fall)
    );

    assign sdi_s       = pin_lvl[0];
    assign framed      = !pin_lvl[2];
    assign frame_start = pin_fall[2];
    assign frame_end   = pin_rise[2];
    // an sclk fall in the very cycle the frame opens is not counted
    assign shift_en    = pin_fall[1] && framed && !frame_start;
    // the fifteenth edge alone is not enough; sixteen are needed
    assign commit      = frame_end && (cnt_reg >= CNT_FULL);

    // count falling edges in the frame, restart at frame start
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
            cnt_reg <= CNT_ZERO;
        else if (frame_start)
            cnt_reg <= CNT_ZERO;
        else if (shift_en && cnt_reg != CNT_MAX)  // saturate, no wrap
            cnt_reg <= cnt_reg + 5'h01;
    end

    // shift register, msb first in, last sixteen bits kept
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
            shift_reg <= WORD_RST;
        else if (shift_en)
            shift_reg <= {shift_reg[WORD_W-2:0], sdi_s};
    end

    // chain output: the bit pushed out of the top, only past edge 16
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
            sdo_reg <= 1'b0;
        else if (!framed)
            sdo_reg <= 1'b0;                      // idle low between frames
        else if (shift_en)
        begin
            if (cnt_reg >= CNT_FULL)
                sdo_reg <= shift_reg[WORD_W-1];
            else
                sdo_reg <= 1'b0;
        end
    end

    // one clock domain; checks rest while reset is held
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);

    // per-channel codes; a channel changes only on a commit aimed at it
    generate
        for (genvar i = 0; i < CHAN_N; i++)
        begin : g_chan
            always_ff @(posedge I_CLK)
            begin
                if (I_SYS_RST)
                    code_reg[i] <= CODE_RST;
                else if (commit &&
                         chan_hit(shift_reg[CMD_MSB:CMD_LSB], i))
                    code_reg[i] <= shift_reg[DATA_MSB:DATA_LSB];
            end
            assign O_CODE[i*CODE_W +: CODE_W] = code_reg[i];

            // a write to this channel lands its data field
            property p_code_write;
                commit && chan_hit(shift_reg[CMD_MSB:CMD_LSB], i)
                |=> code_reg[i] == $past(shift_reg[DATA_MSB:DATA_LSB]);
            endproperty
            a_code_write: assert property (p_code_write)
                else $error("channel code not loaded on commit");
        end
    endgenerate

    // power-down mask command
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
            pd_reg <= MASK_RST;
        else if (commit && shift_reg[CMD_MSB:CMD_LSB] == CMD_PWR)
            pd_reg <= shift_reg[MASK_MSB:MASK_LSB];
    end

    // committed word and strobes; aborts raise abort_reg and leave word_reg alone
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            word_reg  <= WORD_RST;
            upd_reg   <= 1'b0;
            abort_reg <= 1'b0;
        end
        else
        begin
            upd_reg   <= commit;
            abort_reg <= frame_end && !commit;
            if (commit)
                word_reg <= shift_reg;
        end
    end

    // helper for checks: has any complete frame landed yet
    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
            seen_reg <= 1'b0;
        else if (commit)
            seen_reg <= 1'b1;
    end

    assign O_SDO_CHAIN = sdo_reg;
    assign O_PWR_DOWN  = pd_reg;
    assign O_WORD      = word_reg;
    assign O_UPDATE    = upd_reg;
    assign O_ABORT     = abort_reg;

    // each framed fall takes exactly the synced data bit
    property p_shift_in;
        shift_en |=> shift_reg == {$past(shift_reg[WORD_W-2:0]),
                                   $past(sdi_s)};
    endproperty
    a_shift_in: assert property (p_shift_in)
        else $error("data bit not shifted on framed fall");

    // outside a frame falls do not move the register
    property p_no_shift_idle;
        pin_fall[1] && !framed |=> $stable(shift_reg);
    endproperty
    a_no_shift_idle: assert property (p_no_shift_idle)
        else $error("shift register moved outside frame");

    // commit yields one update pulse with the captured word
    property p_commit;
        commit |=> O_UPDATE && !O_ABORT && O_WORD == $past(shift_reg)
                   ##1 !O_UPDATE;
    endproperty
    a_commit: assert property (p_commit)
        else $error("complete frame not committed");

    // short frame: abort pulse, nothing changes
    property p_abort;
        frame_end && cnt_reg < CNT_FULL
        |=> O_ABORT && !O_UPDATE && $stable(O_WORD)
            && $stable(O_CODE) && $stable(O_PWR_DOWN);
    endproperty
    a_abort: assert property (p_abort)
        else $error("short frame changed state");

    // chain output high only once past sixteen edges in a frame; the
    // registered bit may linger the one cycle in which the rise is seen
    property p_chain_quiet;
        O_SDO_CHAIN |-> $past(framed) && cnt_reg >= CNT_CHAIN;
    endproperty
    a_chain_quiet: assert property (p_chain_quiet)
        else $error("chain output active too early");

    // surplus bit leaves in order of arrival
    property p_chain_order;
        shift_en && cnt_reg >= CNT_FULL
        |=> O_SDO_CHAIN == $past(shift_reg[WORD_W-1]);
    endproperty
    a_chain_order: assert property (p_chain_order)
        else $error("chain output bit out of order");

    // zero codes until the first valid frame
    property p_zero_start;
        !seen_reg |-> O_CODE == '0;
    endproperty
    a_zero_start: assert property (p_zero_start)
        else $error("code nonzero before first write");

    // main scenarios
    c_commit:  cover property (commit);
    c_abort:   cover property (frame_end && cnt_reg < CNT_FULL);
    c_chain:   cover property (O_SDO_CHAIN ##[1:200] commit);
    c_pwr:     cover property (commit &&
                   shift_reg[CMD_MSB:CMD_LSB] == CMD_PWR);
endmodule

/* File: tb/host_model.sv */
`timescale 1ns/1ps
module host_model
(
    // chained data coming back from the device
    input  wire logic i_sdo,
    // link pins toward the device
    output logic      o_sclk,
    output logic      o_frame_n,
    output logic      o_sdi
);
    logic [31:0] sdo_seen; // chain level seen after each fall
    // idle link: frame high, clock parked high
    initial
    begin
        o_sclk    = 1'b1;
        o_frame_n = 1'b1;
        o_sdi     = 1'b0;
        sdo_seen  = '0;
    end
    // n bits msb first; clock runs only inside the frame, 48 ns period
    task automatic frame(input logic [31:0] bits, input int n);
        #7 o_frame_n = 1'b0;
        #24;
        for (int k = 0; k < n; k++)
        begin
            o_sdi = bits[n-1-k]; // data settles a half period ahead
            #24 o_sclk = 1'b0; // falling edge carries the bit
            #24 sdo_seen[k] = i_sdo;
            o_sclk = 1'b1;
        end
        #24 o_frame_n = 1'b1; // rise after the last fall ends it
        o_sdi = ~o_sdi; // a released line must not show a stale bit
        #24;
    endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
    begin \
        comparisons++; \
        if ((gt) !== (ex)) \
        begin \
            err_count++; \
            $display("[FAIL] %s exp %h got %h", nm, ex, gt); \
        end \
    end
module tb
    import dac_link_pkg::*;
;
    logic                     clk;         // system clock
    logic                     rst;         // synchronous reset
    wire logic                sclk;        // link clock from host
    wire logic                frame_n;     // frame select from host
    wire logic                sdi;         // serial data from host
    logic                     sdo;         // chained output
    logic [CHAN_N*CODE_W-1:0] code;        // channel codes
    logic [CHAN_N-1:0]        pwr;         // power-down mask
    logic [WORD_W-1:0]        word;        // committed word
    logic                     upd;         // commit pulse
    logic                     abt;         // abort pulse
    int                       err_count;   // mismatches
    int                       comparisons; // checks made
    int                       upd_cnt;     // commit pulses seen
    int                       abt_cnt;     // abort pulses seen
    int                       du;          // commits in one frame
    int                       da;          // aborts in one frame

    dac_frame_input u_dut (.I_CLK(clk), .I_SYS_RST(rst), .I_SCLK(sclk),
        .I_FRAME_N(frame_n), .I_SDI(sdi), .O_SDO_CHAIN(sdo),
        .O_CODE(code), .O_PWR_DOWN(pwr), .O_WORD(word),
        .O_UPDATE(upd), .O_ABORT(abt));
    // chain output feeds the host return line
    host_model u_host (.i_sdo(sdo), .o_sclk(sclk), .o_frame_n(frame_n),
        .o_sdi(sdi));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // count one-cycle pulses so no check depends on the exact cycle
    initial
    begin
        upd_cnt = 0;
        abt_cnt = 0;
    end
    // sampled mid-cycle, away from the edge that launches the pulse
    always @(negedge clk)
    begin
        if (upd === 1'b1)
            upd_cnt++;
        if (abt === 1'b1)
            abt_cnt++;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // one frame, then bounded wait for its end pulse
    task automatic send(input logic [31:0] bits, input int n);
        int u0;
        int a0;
        int w;
        u0 = upd_cnt;
        a0 = abt_cnt;
        w = 0;
        @(posedge clk);
        #1 u_host.frame(bits, n);
        while (upd_cnt == u0 && abt_cnt == a0 && w < 40)
        begin
            @(posedge clk);
            w++;
        end
        if (w >= 40)
        begin
            err_count++;
            test_done();
        end
        else
        begin
            repeat (4) @(posedge clk);
            du = upd_cnt - u0;
            da = abt_cnt - a0;
        end
    endtask

    task automatic t_reset;
        `CHK("code", 64'h0, code)
        `CHK("pwr", 8'h00, pwr)
        `CHK("word", 16'h0000, word)
        `CHK("chain idle", 1'b0, sdo)
        $display("test reset done");
    endtask

    task automatic t_single;
        send(32'h3a50, 16);
        `CHK("commits", 1, du)
        `CHK("aborts", 0, da)
        `CHK("word", 16'h3a50, word)
        `CHK("code", 64'h00000000a5000000, code)
        `CHK("pwr", 8'h00, pwr)
        `CHK("chain quiet", 16'h0000, u_host.sdo_seen[15:0])
        $display("test single done");
    endtask

    task automatic t_all_pwr;
        send(32'h83c0, 16);
        `CHK("code all", 64'h3c3c3c3c3c3c3c3c, code)
        send(32'h905a, 16);
        `CHK("pwr", 8'h5a, pwr)
        `CHK("code kept", 64'h3c3c3c3c3c3c3c3c, code)
        $display("test broadcast done");
    endtask

    // one bit and fifteen bits: both short of a full word
    task automatic t_abort;
        int lens[2];
        lens = '{1, 15};
        foreach (lens[i])
        begin
            send(32'h1ff0 >> (16 - lens[i]), lens[i]);
            `CHK("aborts", 1, da)
            `CHK("commits", 0, du)
            `CHK("word kept", 16'h905a, word)
            `CHK("code kept", 64'h3c3c3c3c3c3c3c3c, code)
            `CHK("pwr kept", 8'h5a, pwr)
        end
        $display("test abort done");
    endtask

    task automatic t_chain;
        logic [15:0] first;
        first = 16'h2c30;
        send({first, 16'h7e10}, 32);
        `CHK("word", 16'h7e10, word)
        `CHK("code", 64'he13c3c3c3c3c3c3c, code)
        `CHK("chain quiet", 16'h0000, u_host.sdo_seen[15:0])
        for (int j = 0; j < 16; j++)
            `CHK("chain bit", first[15-j], u_host.sdo_seen[16+j])
        `CHK("chain after frame", 1'b0, sdo)
        // unknown command: word and strobe only, channels untouched
        send(32'hb7ff, 16);
        `CHK("commits", 1, du)
        `CHK("word", 16'hb7ff, word)
        `CHK("code kept", 64'he13c3c3c3c3c3c3c, code)
        `CHK("pwr kept", 8'h5a, pwr)
        $display("test chain done");
    endtask

    // reset again mid-run: all back to zero, short frame keeps zeros
    task automatic t_rerun;
        @(posedge clk);
        #1 rst = 1'b1;
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        `CHK("code", 64'h0, code)
        `CHK("pwr", 8'h00, pwr)
        `CHK("word", 16'h0000, word)
        `CHK("chain idle", 1'b0, sdo)
        send(32'h0ff8, 15);
        `CHK("aborts", 1, da)
        `CHK("code zero", 64'h0, code)
        send(32'h0120, 16);
        `CHK("commits", 1, du)
        `CHK("code", 64'h0000000000000012, code)
        $display("test rerun done");
    endtask

    initial
    begin
        #200000;
        err_count++;
        test_done();
    end

    initial
    begin
        err_count = 0;
        comparisons = 0;
        rst = 1'b1;
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        t_reset();
        t_single();
        t_all_pwr();
        t_abort();
        t_chain();
        t_rerun();
        test_done();
    end
endmodule
